// file: rtl/pre_defines.svh
`ifndef PRE_DEFINES_SVH
`define PRE_DEFINES_SVH
// How it works
// - multicast keys compared with every masked entry; hit reads its route word.
// - each entry has its own mask; don't-care bits may be anywhere.
// - unmatched external multicast with emer[1] clear goes to the link opposite its receive link.
// - tables writable at any time by a local processor; care advised.
// - point-to-point destination id indexes a 64K by 8-bit table.
// - table word: monitor bit, six link bits, parity bit; several bits multicast.
// - normal nearest-neighbour packets from a link go to the monitor.
// - local nearest-neighbour packets go to the selected link, all links or the monitor.
// - direct packet with payload writes payload to its address on the interconnect.
// - direct packet without payload reads the address and returns data to sender.
// - router keeps a 2-bit time phase.
// - local multicast and point-to-point packets get the current phase stamped.
// - off-chip multicast or point-to-point packet two phases old goes only to the monitor.
// - parity, age or length error sends the packet only to the monitor.
// - computed-route engine makes default and error decisions for every packet.
// - error details are shown on error status outputs.
// - multicast table has 1024 entries.
// - multicast engine only for error-free multicast; computed route always.
// - routing word has one bit per link and per local processor.
`define PRE_MC_ENTRIES  1024
`define PRE_P2P_DEPTH   65536
`define PRE_FIFO_DEPTH  16
`define PRE_NUM_LINKS   6
`define PRE_NUM_DEST    26
`define PRE_SRC_LOCAL   3'h7
`define PRE_NN_MON      3'h7
`define PRE_NN_ALL      3'h6
`define PRE_SEL_KEY     2'h0
`define PRE_SEL_MASK    2'h1
`define PRE_SEL_ROUTE   2'h2
`define PRE_SEL_P2P     2'h3
`define PRE_PHASE_RST   2'h0
`endif

// file: rtl/pre_pkg.sv
package pre_pkg;
   typedef enum logic [1:0] {PT_MC = 2'b00, PT_P2P = 2'b01, PT_NN = 2'b10} pre_ptype_t;
   typedef enum logic [1:0] {S_IDLE = 2'b00, S_SYS = 2'b01, S_RET = 2'b10} pre_state_t;
   typedef struct packed {
      logic [1:0]  ptype;
      logic [1:0]  emer;
      logic [1:0]  tstamp;
      logic        direct;
      logic        has_data;
      logic        eop;
      logic        parity;
      logic [31:0] key;
      logic [31:0] data;
   } pre_pkt_t;
   typedef struct packed {
      logic [25:0] vect;
      pre_pkt_t    pkt;
   } pre_route_t;
   typedef struct packed {
      logic par;
      logic age;
      logic len;
   } pre_err_t;
endpackage

// file: rtl/pre_router.sv
`timescale 1ns/1ps
`include "pre_defines.svh"

module pre_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wr_r;
   logic [AW:0]  rd_r;
   wire          full_w  = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
   wire          empty_w = (wr_r == rd_r);
   assign in_ready_o  = !full_w;
   assign out_valid_o = !empty_w;
   assign out_data_o  = mem[rd_r[AW-1:0]];
   always_ff @(posedge clk_i) begin
      if (in_valid_i && !full_w) mem[wr_r[AW-1:0]] <= in_data_i;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (in_valid_i && !full_w) wr_r <= wr_r + 1'b1;
         if (out_ready_i && !empty_w) rd_r <= rd_r + 1'b1;
      end
   end
endmodule

module pre_router #(
   parameter int MC_ENTRIES = `PRE_MC_ENTRIES,
   parameter int P2P_DEPTH  = `PRE_P2P_DEPTH,
   parameter int FIFO_DEPTH = `PRE_FIFO_DEPTH
) (
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // packet from arbiter
   input  wire logic              in_valid_i,
   output logic                   in_ready_o,
   input  wire pre_pkg::pre_pkt_t in_pkt_i,
   input  wire logic [2:0]        in_src_i,
   // routed packets toward output buffers
   output logic                   out_valid_o,
   input  wire logic              out_ready_i,
   output pre_pkg::pre_route_t    out_route_o,
   // node setup
   input  wire logic [4:0]        mp_id_i,
   input  wire logic              phase_adv_i,
   output logic [1:0]             phase_o,
   // configuration port for tables
   input  wire logic              cfg_we_i,
   input  wire logic [1:0]        cfg_sel_i,
   input  wire logic [15:0]       cfg_addr_i,
   input  wire logic [31:0]       cfg_wdata_i,
   output logic [31:0]            cfg_rdata_o,
   // error details for monitor
   output pre_pkg::pre_err_t      err_flags_o,
   output logic [31:0]            err_key_o,
   input  wire logic              err_clr_i,
   // system interconnect access
   output logic                   sys_req_o,
   output logic                   sys_we_o,
   output logic [31:0]            sys_addr_o,
   output logic [31:0]            sys_wdata_o,
   input  wire logic              sys_ack_i,
   input  wire logic [31:0]       sys_rdata_i
);
   import pre_pkg::*;
   localparam int MCW = $clog2(MC_ENTRIES);
   localparam int PW  = $clog2(P2P_DEPTH);

   logic [31:0]           mc_key  [MC_ENTRIES];
   logic [31:0]           mc_mask [MC_ENTRIES];
   logic [25:0]           mc_rt   [MC_ENTRIES];
   logic [MC_ENTRIES-1:0] mc_vld_r;
   logic [7:0]            p2p_tab [P2P_DEPTH];
   pre_state_t            state_r;
   logic [1:0]            phase_r;
   pre_route_t            hold_r;
   logic                  fifo_ready_w;
   pre_pkt_t              p_w;
   pre_err_t              e_w;
   logic                  err_w;
   logic                  hit_w;
   logic [25:0]           mc_vect_w;
   logic [25:0]           vect_w;
   logic [25:0]           dflt_w;

   // error checks; parity odd over every bit but the length marker
   wire        par_bad_w = ~^{in_pkt_i.ptype, in_pkt_i.emer, in_pkt_i.tstamp, in_pkt_i.direct,
                              in_pkt_i.has_data, in_pkt_i.parity, in_pkt_i.key, in_pkt_i.data};
   wire        ext_w     = in_src_i < 3'(`PRE_NUM_LINKS);
   wire        age_bad_w = ext_w && (in_pkt_i.tstamp == (phase_r ^ 2'h3)) && !in_pkt_i.ptype[1];
   assign e_w   = '{par: par_bad_w, age: age_bad_w, len: !in_pkt_i.eop};
   assign err_w = |e_w;

   // phase stamp on local multicast and point-to-point packets, parity refreshed
   wire        stamp_w = (in_src_i == `PRE_SRC_LOCAL) && !in_pkt_i.ptype[1];
   always_comb begin
      p_w = in_pkt_i;
      if (stamp_w) begin
         p_w.tstamp = phase_r;
         p_w.parity = in_pkt_i.parity ^ ^(in_pkt_i.tstamp ^ phase_r);
      end
   end

   wire [25:0] mon_w   = 26'(1) << (6'(mp_id_i) + 6'd6);
   wire [2:0]  src_p3w = (in_src_i >= 3'h3) ? in_src_i - 3'h3 : in_src_i + 3'h3;
   wire [2:0]  src_p2w = (in_src_i >= 3'h4) ? in_src_i - 3'h4 : in_src_i + 3'h2;
   wire        en_mc_w = !err_w && (in_pkt_i.ptype == PT_MC) && (in_pkt_i.emer != 2'b10);
   wire [2:0]  nn_rt_w = in_pkt_i.key[2:0];

   // associative search, lowest entry wins
   always_comb begin
      hit_w     = 1'b0;
      mc_vect_w = '0;
      for (int i = MC_ENTRIES - 1; i >= 0; i--) begin
         if (en_mc_w && mc_vld_r[i] && (((in_pkt_i.key ^ mc_key[i]) & ~mc_mask[i]) == '0)) begin
            hit_w     = 1'b1;
            mc_vect_w = mc_rt[i];
         end
      end
   end

   wire [7:0]  p2p_w  = p2p_tab[in_pkt_i.key[PW-1:0]];
   wire        nn_direct_w = (in_pkt_i.ptype == PT_NN) && ext_w && in_pkt_i.direct;

   // computed-route engine: default, nearest-neighbour and error routes
   always_comb begin
      dflt_w = '0;
      if (!ext_w) dflt_w = mon_w;
      else if (!in_pkt_i.emer[1]) dflt_w = 26'(1) << src_p3w;
      else if (in_pkt_i.emer == 2'b11) dflt_w = 26'(1) << src_p2w;
      vect_w = '0;
      if (err_w) vect_w = mon_w;
      else begin
         case (in_pkt_i.ptype)
            PT_MC:  vect_w = hit_w ? mc_vect_w : dflt_w;
            PT_P2P: vect_w = {p2p_w[0] ? mon_w[25:6] : 20'h0, p2p_w[6:1]};
            PT_NN: begin
               if (!ext_w) begin
                  if (nn_rt_w == `PRE_NN_MON) vect_w = mon_w;
                  else if (nn_rt_w == `PRE_NN_ALL) vect_w = 26'h00003F;
                  else vect_w = 26'(1) << nn_rt_w;
               end else if (!in_pkt_i.direct) vect_w = mon_w;
            end
            default: vect_w = mon_w;
         endcase
      end
   end

   wire        take_w  = in_valid_i && (state_r == S_IDLE) && fifo_ready_w;
   wire        sys_w   = take_w && !err_w && nn_direct_w;
   wire        push_w  = (take_w && !sys_w) || (state_r == S_RET);
   wire        fire_w  = take_w && !sys_w;
   pre_route_t push_d_w;
   assign push_d_w   = (state_r == S_RET) ? hold_r : '{vect: vect_w, pkt: p_w};
   assign in_ready_o = (state_r == S_IDLE) && fifo_ready_w;
   assign phase_o    = phase_r;

   pre_fifo #(.W($bits(pre_route_t)), .D(FIFO_DEPTH)) u_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (push_w),
      .in_ready_o  (fifo_ready_w),
      .in_data_i   (push_d_w),
      .out_valid_o (out_valid_o),
      .out_ready_i (out_ready_i),
      .out_data_o  (out_route_o)
   );

   // tables: no reset, any-time writes from the configuration port
   always_ff @(posedge clk_i) begin
      if (cfg_we_i) begin
         case (cfg_sel_i)
            `PRE_SEL_KEY:   mc_key[cfg_addr_i[MCW-1:0]]  <= cfg_wdata_i;
            `PRE_SEL_MASK:  mc_mask[cfg_addr_i[MCW-1:0]] <= cfg_wdata_i;
            `PRE_SEL_ROUTE: mc_rt[cfg_addr_i[MCW-1:0]]   <= cfg_wdata_i[25:0];
            default:        p2p_tab[cfg_addr_i[PW-1:0]]  <= cfg_wdata_i[7:0];
         endcase
      end
   end

   wire [31:0] rd_w = (cfg_sel_i == `PRE_SEL_KEY)   ? mc_key[cfg_addr_i[MCW-1:0]] :
                      (cfg_sel_i == `PRE_SEL_MASK)  ? mc_mask[cfg_addr_i[MCW-1:0]] :
                      (cfg_sel_i == `PRE_SEL_ROUTE) ? {6'h00, mc_rt[cfg_addr_i[MCW-1:0]]} :
                                                      {24'h000000, p2p_tab[cfg_addr_i[PW-1:0]]};

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mc_vld_r    <= '0;
         cfg_rdata_o <= 32'h00000000;
         phase_r     <= `PRE_PHASE_RST;
      end else begin
         cfg_rdata_o <= rd_w;
         if (cfg_we_i && cfg_sel_i == `PRE_SEL_KEY) mc_vld_r[cfg_addr_i[MCW-1:0]] <= 1'b1;
         // gray order 0,1,3,2: a stamp two phases back differs in both bits
         if (phase_adv_i) phase_r <= {phase_r[0], ~phase_r[1]};
      end
   end

   // error details; a new error wins over a clear in the same cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         err_flags_o <= '0;
         err_key_o   <= 32'h00000000;
      end else if (take_w && err_w) begin
         err_flags_o <= e_w;
         err_key_o   <= in_pkt_i.key;
      end else if (err_clr_i) begin
         err_flags_o <= '0;
      end
   end

   // direct nearest-neighbour access on the system interconnect
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r     <= S_IDLE;
         hold_r      <= '0;
         sys_req_o   <= 1'b0;
         sys_we_o    <= 1'b0;
         sys_addr_o  <= 32'h00000000;
         sys_wdata_o <= 32'h00000000;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (sys_w) begin
                  state_r     <= S_SYS;
                  sys_req_o   <= 1'b1;
                  sys_we_o    <= in_pkt_i.has_data;
                  sys_addr_o  <= in_pkt_i.key;
                  sys_wdata_o <= in_pkt_i.data;
                  hold_r      <= '{vect: 26'(1) << in_src_i, pkt: in_pkt_i};
               end
            end
            S_SYS: begin
               if (sys_ack_i) begin
                  sys_req_o <= 1'b0;
                  state_r   <= sys_we_o ? S_IDLE : S_RET;
                  hold_r.pkt.data     <= sys_rdata_i;
                  hold_r.pkt.has_data <= 1'b1;
                  hold_r.pkt.direct   <= 1'b0;
                  hold_r.pkt.parity   <= hold_r.pkt.parity ^ ^sys_rdata_i ^ ^hold_r.pkt.data
                                         ^ hold_r.pkt.has_data ^ 1'b1 ^ hold_r.pkt.direct;
               end
            end
            S_RET: begin
               if (fifo_ready_w) state_r <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_read_issue;
      sys_w && !in_pkt_i.has_data;
   endsequence
   sequence s_read_done;
      sys_req_o && !sys_we_o && sys_ack_i;
   endsequence

   property p_err_only_mon;
      fire_w && err_w |-> push_d_w.vect == mon_w;
   endproperty
   a_err_only_mon: assert property (p_err_only_mon) else $error("errored packet not sent to monitor only");

   property p_default_opp;
      fire_w && !err_w && in_pkt_i.ptype == PT_MC && !hit_w && ext_w && !in_pkt_i.emer[1]
         |-> push_d_w.vect == 26'(1) << ((4'(in_src_i) + 4'h3) % 4'h6);
   endproperty
   a_default_opp: assert property (p_default_opp) else $error("default route not opposite link");

   property p_stamp;
      fire_w && in_src_i == `PRE_SRC_LOCAL && !in_pkt_i.ptype[1] |-> push_d_w.pkt.tstamp == phase_r;
   endproperty
   a_stamp: assert property (p_stamp) else $error("local packet not stamped");

   property p_age;
      take_w && ext_w && !in_pkt_i.ptype[1] && in_pkt_i.tstamp == ~phase_r |-> err_w;
   endproperty
   a_age: assert property (p_age) else $error("stale packet not flagged");

   property p_write;
      sys_w && in_pkt_i.has_data |=> sys_req_o && sys_we_o && sys_addr_o == $past(in_pkt_i.key)
         && sys_wdata_o == $past(in_pkt_i.data);
   endproperty
   a_write: assert property (p_write) else $error("direct write not issued");

   property p_read_return;
      s_read_issue ##[1:20] s_read_done |=> push_w && push_d_w.pkt.has_data
         && push_d_w.pkt.data == $past(sys_rdata_i) && !push_d_w.pkt.direct;
   endproperty
   a_read_return: assert property (p_read_return) else $error("read result not returned");

   property p_p2p;
      fire_w && !err_w && in_pkt_i.ptype == PT_P2P |-> push_d_w.vect[5:0] == p2p_w[6:1];
   endproperty
   a_p2p: assert property (p_p2p) else $error("point-to-point links wrong");

   property p_err_info;
      take_w && err_w && in_pkt_i.eop == 1'b0 |=> err_flags_o.len && err_key_o == $past(in_pkt_i.key);
   endproperty
   a_err_info: assert property (p_err_info) else $error("error details not recorded");
endmodule

// file: verification/pre_sys_model.sv
`timescale 1ns/1ps
module pre_sys_model (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // interconnect slave side
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [31:0] addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic [3:0]  lat_i,
   output logic             ack_o,
   output logic [31:0]      rdata_o
);
   logic [31:0] mem_r [16];
   logic [3:0]  cnt_r;
   // one-cycle ack after lat_i waits; read data toggles outside the ack cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o <= 1'b0;
         cnt_r <= 4'h0;
         rdata_o <= 32'h0;
      end else if (req_i && !ack_o && cnt_r >= lat_i) begin
         ack_o <= 1'b1;
         cnt_r <= 4'h0;
         rdata_o <= mem_r[addr_i[3:0]];
         if (we_i) mem_r[addr_i[3:0]] <= wdata_i;
      end else begin
         ack_o <= 1'b0;
         rdata_o <= ~rdata_o;
         cnt_r <= (req_i && !ack_o) ? cnt_r + 4'h1 : 4'h0;
      end
   end
endmodule

// file: verification/pre_router_tb_top.sv
`timescale 1ns/1ps
module pre_router_tb_top;
   import pre_pkg::*;
   typedef struct packed {
      logic [2:0]  src;
      logic [1:0]  ty;
      logic [1:0]  ts;
      logic        eop;
      logic        bad;
      logic [31:0] key;
      logic [31:0] vect;
      logic [1:0]  ets;
   } pre_row_t;
   logic clk_i = 0, rst_n_i = 0, in_valid_i = 0, out_ready_i = 0, phase_adv_i = 0;
   logic cfg_we_i = 0, err_clr_i = 0, in_ready_o, out_valid_o, sys_req_o, sys_we_o, sys_ack_i;
   logic [2:0]  in_src_i = 0;
   logic [1:0]  cfg_sel_i = 0, phase_o;
   logic [15:0] cfg_addr_i = 0;
   logic [31:0] cfg_wdata_i = 0, cfg_rdata_o, err_key_o, sys_addr_o, sys_wdata_o, sys_rdata_i;
   logic [3:0]  lat = 0;
   pre_pkt_t    in_pkt_i = '0;
   pre_route_t  out_route_o;
   pre_pkt_t    pk;
   pre_err_t    err_flags_o;
   int fail_count = 0, checks = 0, i;
   pre_row_t rows [11] = '{
      '{3'h1, 2'h0, 2'h0, 1'b1, 1'b0, 32'h8013, 32'hA0, 2'h0},
      '{3'h1, 2'h0, 2'h0, 1'b1, 1'b0, 32'h8033, 32'h10, 2'h0},
      '{3'h5, 2'h0, 2'h1, 1'b1, 1'b0, 32'h0777, 32'h04, 2'h1},
      '{3'h7, 2'h0, 2'h1, 1'b1, 1'b0, 32'h0777, 32'h100, 2'h0},
      '{3'h7, 2'h1, 2'h2, 1'b1, 1'b0, 32'h0005, 32'h103, 2'h0},
      '{3'h3, 2'h2, 2'h0, 1'b1, 1'b0, 32'h0000, 32'h100, 2'h0},
      '{3'h7, 2'h2, 2'h0, 1'b1, 1'b0, 32'h0006, 32'h3F, 2'h0},
      '{3'h7, 2'h2, 2'h0, 1'b1, 1'b0, 32'h0002, 32'h04, 2'h0},
      '{3'h1, 2'h0, 2'h0, 1'b1, 1'b1, 32'h8013, 32'h100, 2'h0},
      '{3'h1, 2'h0, 2'h0, 1'b0, 1'b0, 32'h8013, 32'h100, 2'h0},
      '{3'h2, 2'h1, 2'h3, 1'b1, 1'b0, 32'h0005, 32'h100, 2'h3}};
   pre_router #(.MC_ENTRIES(16), .P2P_DEPTH(256), .FIFO_DEPTH(4)) i_pre_router (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .in_pkt_i(in_pkt_i),
      .in_src_i(in_src_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_route_o(out_route_o),
      .mp_id_i(5'h02), .phase_adv_i(phase_adv_i), .phase_o(phase_o), .cfg_we_i(cfg_we_i),
      .cfg_sel_i(cfg_sel_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
      .err_flags_o(err_flags_o), .err_key_o(err_key_o), .err_clr_i(err_clr_i), .sys_req_o(sys_req_o),
      .sys_we_o(sys_we_o), .sys_addr_o(sys_addr_o), .sys_wdata_o(sys_wdata_o), .sys_ack_i(sys_ack_i),
      .sys_rdata_i(sys_rdata_i));
   pre_sys_model i_pre_sys_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(sys_req_o), .we_i(sys_we_o),
      .addr_i(sys_addr_o), .wdata_i(sys_wdata_o), .lat_i(lat), .ack_o(sys_ack_i), .rdata_o(sys_rdata_i));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic tick(int n = 1);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic timeout();
      fail_count++;
      $display("MISMATCH %0t wait ran out", $time);
      conclude();
   endtask
   // odd parity over every field except eop
   function automatic pre_pkt_t mk(logic [1:0] ty, logic [1:0] ts, logic dir, logic hd, logic eop, logic bad,
                                   logic [31:0] key, logic [31:0] d);
      pre_pkt_t p;
      p = '{ptype: ty, emer: 2'h0, tstamp: ts, direct: dir, has_data: hd, eop: eop, parity: 1'b0, key: key, data: d};
      p.parity = ~(^{p.ptype, p.emer, p.tstamp, p.direct, p.has_data, p.key, p.data}) ^ bad;
      return p;
   endfunction
   task automatic push(pre_pkt_t p, logic [2:0] s);
      int n;
      n = 0;
      in_pkt_i = p;
      in_src_i = s;
      in_valid_i = 1;
      while (in_ready_o !== 1'b1) begin
         if (++n > 50) timeout();
         tick();
      end
      tick();
      in_valid_i = 0;
      tick();
   endtask
   task automatic take(logic [31:0] v, logic [1:0] ts, logic chkd = 1'b0, logic [31:0] d = 32'h0);
      int n;
      n = 0;
      while (out_valid_o !== 1'b1) begin
         if (++n > 50) timeout();
         tick();
      end
      chk(32'(out_route_o.vect), v, "route vector");
      chk(32'(out_route_o.pkt.tstamp), 32'(ts), "time stamp");
      if (chkd) chk(out_route_o.pkt.data, d, "payload");
      out_ready_i = 1;
      tick();
      out_ready_i = 0;
      tick();
   endtask
   task automatic cfg(logic [1:0] sel, logic [15:0] a, logic [31:0] d);
      cfg_sel_i = sel;
      cfg_addr_i = a;
      cfg_wdata_i = d;
      cfg_we_i = 1;
      tick();
      cfg_we_i = 0;
      tick();
   endtask
   initial begin
      tick(4);
      chk(32'({in_ready_o, out_valid_o, sys_req_o, phase_o}), 32'h10, "reset outputs");
      $display("test reset done");
      rst_n_i = 1;
      tick();
      cfg(2'h1, 16'h0, 32'h8001);
      cfg(2'h2, 16'h0, 32'hA0);
      cfg(2'h0, 16'h0, 32'h0012);
      cfg(2'h3, 16'h5, 32'h07);
      cfg_sel_i = 2'h2;
      cfg_addr_i = 16'h0;
      tick();
      chk(cfg_rdata_o, 32'hA0, "route readback");
      for (i = 0; i < 11; i++) begin
         push(mk(rows[i].ty, rows[i].ts, 1'b0, 1'b0, rows[i].eop, rows[i].bad, rows[i].key, 32'h0), rows[i].src);
         take(rows[i].vect, rows[i].ets);
      end
      $display("test table done");
      chk(32'(err_flags_o), 32'h2, "age flag");
      chk(err_key_o, 32'h0005, "error key");
      err_clr_i = 1;
      tick();
      err_clr_i = 0;
      chk(32'(err_flags_o), 32'h0, "flags cleared");
      push(mk(2'h0, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1, 32'h55, 32'h0), 3'h1);
      take(32'h100, 2'h0);
      chk(32'(err_flags_o), 32'h4, "parity flag");
      $display("test error details done");
      repeat (2) begin
         phase_adv_i = 1;
         tick();
      end
      phase_adv_i = 0;
      // phase runs in gray order 0, 1, 3, 2
      chk(32'(phase_o), 32'h3, "phase after two steps");
      push(mk(2'h0, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 32'h8013, 32'h0), 3'h1);
      take(32'h100, 2'h0);
      push(mk(2'h0, 2'h1, 1'b0, 1'b0, 1'b1, 1'b0, 32'h8013, 32'h0), 3'h1);
      take(32'hA0, 2'h1);
      push(mk(2'h1, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 32'h5, 32'h0), 3'h7);
      take(32'h103, 2'h3);
      $display("test time phase done");
      lat = 4'h0;
      push(mk(2'h2, 2'h0, 1'b1, 1'b1, 1'b1, 1'b0, 32'h44, 32'hDEADBEEF), 3'h2);
      chk(32'({sys_req_o, sys_we_o}), 32'h3, "write request");
      chk(sys_addr_o, 32'h44, "write address");
      chk(sys_wdata_o, 32'hDEADBEEF, "write data");
      tick(6);
      chk(32'(out_valid_o), 32'h0, "write routes nowhere");
      lat = 4'h3;
      push(mk(2'h2, 2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 32'h44, 32'h0), 3'h4);
      chk(32'({sys_req_o, sys_we_o, in_ready_o}), 32'h4, "read request busy");
      take(32'h10, 2'h0, 1'b1, 32'hDEADBEEF);
      $display("test direct access done");
      for (i = 0; i < 4; i++) push(mk(2'h2, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 32'h2, 32'h0), 3'h7);
      chk(32'(in_ready_o), 32'h0, "full buffer refuses");
      for (i = 0; i < 4; i++) take(32'h04, 2'h0);
      chk(32'(out_valid_o), 32'h0, "buffer drained");
      $display("test buffer done");
      // second-stage emergency miss: two flipped bits keep parity
      pk = mk(2'h0, 2'h3, 1'b0, 1'b0, 1'b1, 1'b0, 32'h777, 32'h0);
      pk.emer = 2'h3;
      push(pk, 3'h1);
      take(32'h08, 2'h3);
      $display("test emergency default done");
      conclude();
   end
endmodule
